// ### osc_source.sv
`timescale 1ns/1ps
module osc_source #(
    parameter int DIV = 4           // Clock cycles per oscillator cycle
)(
    input  wire logic clock,
    input  wire logic stop,         // Source removed from the pin
    input  wire logic enable,       // Oscillator powered by the device
    output logic      osc_tick,     // One pulse per oscillator cycle
    output logic      osc_lost      // Missing-clock detector level
);
    logic [7:0] phase_q = 8'h00;    // Position within the oscillator period

    // Free-running phase, seen by the device only as ticks
    always_ff @(posedge clock) begin
        phase_q <= (phase_q == 8'(DIV - 1)) ? 8'h00 : phase_q + 8'h01;
    end

    // No ticks while removed or powered down
    assign osc_tick = !stop && enable && (phase_q == 8'(DIV - 1));
    assign osc_lost = stop;
endmodule

// ### pll_clock_ctrl.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module pll_clock_ctrl
    import pll_clock_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYCLES_DEFAULT
)(
    input  wire logic        clock,
    input  wire logic        rst_n,                // External reset
    input  wire reg_req_t    bus,                  // Register request
    output logic [15:0]      rd_data_q,            // Read data, cycle after strobe
    input  wire logic        protected_write_gate, // Gate for protected writes
    input  wire logic        osc_tick,             // One pulse per oscillator cycle
    input  wire logic        osc_lost,             // Missing-clock detector level
    input  wire logic        debug_reset_req,      // Debugger reset request
    input  wire logic        idle_exec,            // Idle instruction executed
    input  wire logic        irq_pending,          // Any enabled interrupt
    input  wire logic        external_nmi_n,       // Active-low NMI
    input  wire logic        debug_wake,           // Debugger wake request
    input  wire logic [31:0] gpio_a,               // Port A pins, active-low wake
    output logic [3:0]       pll_mult_q,           // Active multiplier, 0 = bypass
    output logic [2:0]       cpu_div_q,            // CPU clock divide factor
    output logic             pll_on_q,             // PLL powered
    output logic             limp_select_q,        // Limp clock feeds the CPU
    output logic             cpu_clock_on_q,       // CPU clock running
    output logic             system_clock_on_q,    // System clock output running
    output logic             osc_on_q,             // Oscillator running
    output logic             pins_hold_q,          // Output pins frozen
    output logic             wake_q,               // Low-power exit pulse
    output logic             watchdog_wake_irq_q,  // Watchdog interrupt/wake
    output logic             device_reset_q        // Device reset pulse
);

    // Stored controls
    logic [3:0]        ratio_q;        // PLL ratio control
    logic [1:0]        cpu_clock_in_divide_select_q;       // Input-clock divide select
    logic              power_off_q;    // PLL power-off bit
    logic              locked_q;       // PLL lock flag
    logic [LOCK_W-1:0] lock_cnt_q;     // Settling counter
    logic              mclk_flag_q;    // Missing-clock flag
    logic              osc_seen_q;     // Oscillator seen since reset
    logic              limp_q;         // Running on limp clock
    logic              wd_mode_q;      // 1: watchdog drives interrupt
    logic              wd_dis_q;       // Watchdog disabled
    logic [1:0]        lp_sel_q;       // Low-power select
    logic [5:0]        qual_q;         // Standby qualification count
    logic [31:0]       wake_sel_q;     // Wake pin select
    logic [6:0]        qual_cnt_q;     // Qualification progress
    lp_state_t         lp_state_q;
    lp_state_t         lp_state_d;

    // Watchdog outputs
    logic [7:0] wd_count;
    logic       wd_pulse;
    logic       wd_start;

    // Address decode
    wire wr_status = bus.wr && (bus.addr == ADDR_PLL_STATUS);
    wire wr_lp     = bus.wr && (bus.addr == ADDR_LOWPOWER);
    wire wr_ratio  = bus.wr && (bus.addr == ADDR_PLL_RATIO) && protected_write_gate;
    wire wr_sys    = bus.wr && (bus.addr == ADDR_SYS_CTRL);
    wire wr_key    = bus.wr && (bus.addr == ADDR_WD_KEY);
    wire wr_wdctl  = bus.wr && (bus.addr == ADDR_WD_CTRL);
    wire wr_sel_lo = bus.wr && (bus.addr == ADDR_WAKE_SEL_LO);
    wire wr_sel_hi = bus.wr && (bus.addr == ADDR_WAKE_SEL_HI);

    // Reset events; a loss counts only once the oscillator has been seen,
    // so a slow start after power-up is not taken for a failure
    wire mclk_evt  = osc_lost && osc_seen_q && !limp_q;
    wire wd_rst    = wd_start && !wd_mode_q;
    wire pll_rst   = !rst_n || wd_rst;
    wire soft_rst  = !rst_n || wd_rst || mclk_evt || debug_reset_req;
    wire halted    = (lp_state_q == LP_HALT);
    wire wd_run    = !wd_dis_q && !limp_q && !halted;

    // PLL runs unless powered off or about to halt; halt stops it with the oscillator
    wire pll_run   = !power_off_q && (lp_state_d != LP_HALT);

    // Wake qualification inputs; a glitch shorter than the count
    // restarts qualification and leaves the device in standby
    wire gpio_low  = |(~gpio_a & wake_sel_q);
    wire nmi_low   = !external_nmi_n;
    wire qual_done = (qual_cnt_q == ({1'b0, qual_q} + 7'd1));

    // Status word
    wire [15:0] status_word = {7'h00, cpu_clock_in_divide_select_q, 2'b00, power_off_q, mclk_flag_q, 2'b00, locked_q};

    // Read data selection
    wire [15:0] rd_mux =
        (bus.addr == ADDR_PLL_STATUS)  ? status_word :
        (bus.addr == ADDR_LOWPOWER)    ? {8'h00, qual_q, lp_sel_q} :
        (bus.addr == ADDR_PLL_RATIO)   ? {12'h000, ratio_q} :
        (bus.addr == ADDR_SYS_CTRL)    ? {14'h0000, wd_mode_q, 1'b0} :
        (bus.addr == ADDR_WD_COUNT)    ? {8'h00, wd_count} :
        (bus.addr == ADDR_WD_CTRL)     ? {9'h000, wd_dis_q, 6'h00} :
        (bus.addr == ADDR_WAKE_SEL_LO) ? wake_sel_q[15:0] :
        (bus.addr == ADDR_WAKE_SEL_HI) ? wake_sel_q[31:16] :
                                         16'h0000;

    // Watchdog counter and pulse
    wd_timer u_wd (
        .clock    (clock),
        .rst_n    (rst_n),
        .clear    (soft_rst),
        .osc_tick (osc_tick),
        .run      (wd_run),
        .key_wr   (wr_key),
        .key_data (bus.wdata[7:0]),
        .count_q  (wd_count),
        .pulse_q  (wd_pulse),
        .start_q  (wd_start)
    );

    // Read port, unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= bus.rd ? rd_mux : 16'h0000;
        end
    end

    // PLL ratio, divide select and power-off; cleared only by the PLL reset
    always_ff @(posedge clock) begin
        if (pll_rst) begin
            ratio_q     <= RATIO_RST;
            cpu_clock_in_divide_select_q    <= CPU_CLOCK_IN_DIVIDE_SELECT_RST;
            power_off_q <= 1'b0;
        end else begin
            if (wr_ratio) begin
                ratio_q <= bus.wdata[3:0];
            end
            if (wr_status) begin
                cpu_clock_in_divide_select_q    <= bus.wdata[CPU_CLOCK_IN_DIVIDE_SELECT_LO +: 2];
                power_off_q <= bus.wdata[OFF_BIT];
            end
        end
    end

    // Lock counter restarts on every ratio write the gate lets through, held at zero while powered off
    // The multiplier output stays in bypass until the count completes
    always_ff @(posedge clock) begin
        if (pll_rst) begin
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end else if (wr_ratio || power_off_q) begin
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end else if (!locked_q && osc_tick) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
            locked_q   <= (lock_cnt_q == LOCK_W'(LOCK_CYCLES - 1));
        end
    end

    // Missing-clock detection; write one clears the flag, a new loss wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            osc_seen_q  <= 1'b0;
            limp_q      <= 1'b0;
            mclk_flag_q <= 1'b0;
        end else begin
            osc_seen_q <= osc_seen_q || osc_tick;
            if (mclk_evt) begin
                limp_q <= 1'b1;
            end
            if (mclk_evt) begin
                mclk_flag_q <= 1'b1;
            end else if (wr_status && bus.wdata[MCLK_BIT]) begin
                mclk_flag_q <= 1'b0;
            end
        end
    end

    // Watchdog and low-power controls, cleared by any device reset
    always_ff @(posedge clock) begin
        if (soft_rst) begin
            wd_mode_q  <= 1'b0;
            wd_dis_q   <= 1'b0;
            lp_sel_q   <= LP_SEL_RST;
            qual_q     <= QUAL_RST;
            wake_sel_q <= 32'h0000_0000;
        end else begin
            if (wr_sys) begin
                wd_mode_q <= bus.wdata[WD_MODE_BIT];
            end
            if (wr_wdctl) begin
                wd_dis_q <= bus.wdata[WD_DIS_BIT];
            end
            if (wr_lp) begin
                lp_sel_q <= bus.wdata[LP_SEL_LO +: 2];
                qual_q   <= bus.wdata[LP_QUAL_LO +: 6];
            end
            if (wr_sel_lo) begin
                wake_sel_q[15:0] <= bus.wdata;
            end
            if (wr_sel_hi) begin
                wake_sel_q[31:16] <= bus.wdata;
            end
        end
    end

    // Standby pin qualification on oscillator cycles
    always_ff @(posedge clock) begin
        if (soft_rst || lp_state_q != LP_STANDBY || !gpio_low) begin
            qual_cnt_q <= 7'd0;
        end else if (osc_tick && !qual_done) begin
            qual_cnt_q <= qual_cnt_q + 7'd1;
        end
    end

    // Low-power next state
    always_comb begin
        lp_state_d = lp_state_q;
        case (lp_state_q)
            LP_RUN: begin
                if (idle_exec) begin
                    case (lp_sel_q)
                        2'b00:   lp_state_d = LP_IDLE;
                        2'b01:   lp_state_d = LP_STANDBY;
                        default: lp_state_d = LP_HALT;
                    endcase
                end
            end
            LP_IDLE: begin
                if (wd_pulse || irq_pending || nmi_low) begin
                    lp_state_d = LP_RUN;
                end
            end
            LP_STANDBY: begin
                if (wd_pulse || qual_done || debug_wake || nmi_low) begin
                    lp_state_d = LP_RUN;
                end
            end
            LP_HALT: begin
                if (gpio_low || debug_wake || nmi_low) begin
                    lp_state_d = LP_RUN;
                end
            end
            default: lp_state_d = LP_RUN;
        endcase
    end

    // Low-power state register
    always_ff @(posedge clock) begin
        if (soft_rst) begin
            lp_state_q <= LP_RUN;
        end else begin
            lp_state_q <= lp_state_d;
        end
    end

    // Registered outputs; clock enables follow the next state so they
    // switch on the same edge as the state register, except on a soft reset, where they follow a cycle late
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pll_mult_q          <= 4'h0;
            cpu_div_q           <= 3'd4;
            pll_on_q            <= 1'b0;
            limp_select_q       <= 1'b0;
            cpu_clock_on_q      <= 1'b0;
            system_clock_on_q   <= 1'b0;
            osc_on_q            <= 1'b0;
            pins_hold_q         <= 1'b0;
            wake_q              <= 1'b0;
            watchdog_wake_irq_q <= 1'b0;
            device_reset_q      <= 1'b0;
        end else begin
            pll_mult_q          <= (pll_run && locked_q && !limp_q) ? ratio_q : 4'h0;
            cpu_div_q           <= divide_factor(cpu_clock_in_divide_select_q);
            pll_on_q            <= pll_run;
            limp_select_q       <= limp_q;
            cpu_clock_on_q      <= (lp_state_d == LP_RUN) || (lp_state_d == LP_IDLE);
            system_clock_on_q   <= (lp_state_d == LP_RUN) || (lp_state_d == LP_IDLE);
            osc_on_q            <= (lp_state_d != LP_HALT);
            pins_hold_q         <= (lp_state_d != LP_RUN);
            wake_q              <= (lp_state_q != LP_RUN) && (lp_state_d == LP_RUN);
            watchdog_wake_irq_q <= wd_pulse && wd_mode_q;
            device_reset_q      <= wd_rst || mclk_evt;
        end
    end

endmodule

// ### pll_clock_ctrl_checker.sv
`timescale 1ns/1ps
module pll_clock_ctrl_checker
    import pll_clock_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire reg_req_t    bus,
    input wire logic        protected_write_gate,
    input wire logic [15:0] rd_data_q,
    input wire logic [3:0]  pll_mult_q,
    input wire logic [2:0]  cpu_div_q,
    input wire logic        pll_on_q,
    input wire logic        limp_select_q,
    input wire logic        cpu_clock_on_q,
    input wire logic        system_clock_on_q,
    input wire logic        osc_on_q,
    input wire logic        pins_hold_q,
    input wire logic        wake_q,
    input wire logic        device_reset_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    wire [1:0] sel_w = bus.wdata[CPU_CLOCK_IN_DIVIDE_SELECT_LO +: 2];  // Divide select being written
    wire [2:0] div_exp;                            // Divide that select asks for
    assign div_exp = (sel_w == 2'h3) ? 3'h1 : (sel_w == 2'h2) ? 3'h2 : 3'h4;

    chk_div_follow:
        assert property (bus.wr && bus.addr == ADDR_PLL_STATUS |-> ##2 cpu_div_q == $past(div_exp, 2))
        else $error("cpu divide does not follow divide select");
    chk_bypass_relock:
        assert property (bus.wr && bus.addr == ADDR_PLL_RATIO && protected_write_gate |-> ##2 pll_mult_q == 4'h0)
        else $error("no bypass after ratio write");
    chk_gate_closed:
        assert property (bus.wr && bus.addr == ADDR_PLL_RATIO && !protected_write_gate |=> $stable(pll_mult_q))
        else $error("ratio changed with gate closed");
    chk_loss_reset:
        assert property ($rose(limp_select_q) |-> $past(device_reset_q))
        else $error("clock loss gave no device reset");
    chk_reset_pulse:
        assert property (device_reset_q |=> !device_reset_q)
        else $error("device reset longer than one cycle");
    chk_off_bypass:
        assert property (!pll_on_q |-> pll_mult_q == 4'h0)
        else $error("multiplier active with pll off");
    chk_halt_stops:
        assert property (!osc_on_q |-> !pll_on_q && !cpu_clock_on_q)
        else $error("clocks running in halt");
    chk_clock_pair:
        assert property (cpu_clock_on_q == system_clock_on_q)
        else $error("cpu and system clock disagree");
    chk_wake_release:
        assert property (wake_q |-> ##[0:1] !pins_hold_q)
        else $error("pins still held after wake");
    chk_rd_quiet:
        assert property (!$past(bus.rd) |-> rd_data_q == 16'h0000)
        else $error("read data outside its cycle");
endmodule

bind pll_clock_ctrl pll_clock_ctrl_checker pll_clock_ctrl_checker_i (.*);

// ### pll_clock_pkg.sv
package pll_clock_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] ADDR_PLL_STATUS  = 8'h11;
    localparam logic [7:0] ADDR_LOWPOWER    = 8'h1E;
    localparam logic [7:0] ADDR_PLL_RATIO   = 8'h21;
    localparam logic [7:0] ADDR_SYS_CTRL    = 8'h22;
    localparam logic [7:0] ADDR_WD_COUNT    = 8'h23;
    localparam logic [7:0] ADDR_WD_KEY      = 8'h25;
    localparam logic [7:0] ADDR_WD_CTRL     = 8'h29;
    localparam logic [7:0] ADDR_WAKE_SEL_LO = 8'h30;
    localparam logic [7:0] ADDR_WAKE_SEL_HI = 8'h31;

    // Field positions
    localparam int LOCK_BIT      = 0;
    localparam int MCLK_BIT      = 3;
    localparam int OFF_BIT       = 4;
    localparam int CPU_CLOCK_IN_DIVIDE_SELECT_LO     = 7;
    localparam int WD_MODE_BIT   = 1;
    localparam int WD_DIS_BIT    = 6;
    localparam int LP_SEL_LO     = 0;
    localparam int LP_QUAL_LO    = 2;

    // Values after reset
    localparam logic [1:0] CPU_CLOCK_IN_DIVIDE_SELECT_RST = 2'h0;
    localparam logic [3:0] RATIO_RST  = 4'h0;
    localparam logic [1:0] LP_SEL_RST = 2'h0;
    localparam logic [5:0] QUAL_RST   = 6'h00;
    localparam logic [7:0] WD_CNT_RST = 8'h00;

    // Watchdog constants
    localparam logic [7:0] WD_MAX      = 8'hFF;
    localparam logic [7:0] KEY_ARM     = 8'h55;
    localparam logic [7:0] KEY_SERVICE = 8'hAA;
    localparam logic [9:0] WD_PULSE_CYCLES = 10'd512;

    // Oscillator cycles the PLL needs to settle after a ratio change
    localparam int LOCK_CYCLES_DEFAULT = 131072;
    localparam int LOCK_W = 18;

    // Low-power states
    typedef enum logic [1:0] {
        LP_RUN     = 2'b00,
        LP_IDLE    = 2'b01,
        LP_STANDBY = 2'b10,
        LP_HALT    = 2'b11
    } lp_state_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // Divide factor applied to the CPU clock input
    function automatic logic [2:0] divide_factor(input logic [1:0] sel);
        case (sel)
            2'd3:    divide_factor = 3'd1;
            2'd2:    divide_factor = 3'd2;
            default: divide_factor = 3'd4;
        endcase
    endfunction

endpackage

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pll_clock_pkg::*;
    localparam int LK = 16;                  // Shortened lock count
    logic        clock = 1'b0;               // System clock
    logic        rst_n = 1'b0;               // External reset
    reg_req_t    bus = '0;                   // Register request
    logic        protected_write_gate = 1'b0;
    logic        stop = 1'b0;                // Oscillator removed
    logic        debug_reset_req = 1'b0;     // Debugger reset request
    logic        idle_exec = 1'b0;
    logic        irq_pending = 1'b0;
    logic        external_nmi_n = 1'b1;
    logic        debug_wake = 1'b0;          // Debugger wake request
    logic [31:0] gpio_a = 32'hFFFF_FFFF;     // Port A, idle high
    logic        osc_tick;
    logic        osc_lost;
    logic [15:0] rd_data_q;
    logic [3:0]  pll_mult_q;
    logic [2:0]  cpu_div_q;
    logic        pll_on_q, limp_select_q, cpu_clock_on_q, system_clock_on_q;
    logic        osc_on_q, pins_hold_q, wake_q, watchdog_wake_irq_q, device_reset_q;
    logic [15:0] v;                          // Read data
    logic [15:0] w;                          // Earlier read data
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;                    // Cycles since start
    int          i;
    int          t;                          // Oscillator ticks seen

    pll_clock_ctrl #(.LOCK_CYCLES(LK)) pll_clock_ctrl_i (.*);
    osc_source osc_source_i (.clock(clock), .stop(stop), .enable(osc_on_q), .osc_tick(osc_tick), .osc_lost(osc_lost));

    always #5 clock = ~clock;

    // Cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report;
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task final_report;
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Outputs are read at the edge, before it updates them
    task pause(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Write, then one idle cycle so strobes never merge
    task wr(input logic [7:0] a, input logic [15:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
        @(posedge clock);
    endtask

    // Read data stand only in the cycle after the strobe; taken at the edge closing it
    task rd(input logic [7:0] a, output logic [15:0] d);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        @(posedge clock);
        d = rd_data_q;
    endtask

    task do_reset;
        rst_n <= 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
    endtask

    task enter(input logic [15:0] mode);
        wr(ADDR_LOWPOWER, mode);
        idle_exec <= 1'b1;
        @(posedge clock);
        idle_exec <= 1'b0;
        pause(2);
    endtask

    // Wake source is held until the device leaves low power
    task wait_wake;
        for (i = 0; i < 100 && pins_hold_q !== 1'b0; i++) pause(1);
        chk("woken", 32'h0, pins_hold_q);
    endtask

    task t_start_divide;
        pause(1);
        chk("mult_rst", 32'h0, pll_mult_q);
        rd(8'h40, v);
        chk("unmapped", 32'h0, v);
        for (i = 3; i >= 0; i--) begin
            wr(ADDR_PLL_STATUS, 16'(i) << CPU_CLOCK_IN_DIVIDE_SELECT_LO);
            pause(2);
            chk("div", (i == 3) ? 1 : (i == 2) ? 2 : 4, cpu_div_q);
        end
    endtask

    task t_ratio;
        wr(ADDR_PLL_RATIO, 16'h0005);
        rd(ADDR_PLL_RATIO, v);
        chk("ratio_closed", 32'h0, v);
        protected_write_gate <= 1'b1;
        wr(ADDR_PLL_RATIO, 16'h0005);
        t = 0;
        for (i = 0; i < 400 && pll_mult_q !== 4'h5; i++) begin
            if (osc_tick === 1'b1) t++;
            pause(1);
        end
        chk("mult", 32'h5, pll_mult_q);
        chk("lock_wait", 32'h1, t >= LK);
        debug_reset_req <= 1'b1;
        pause(1);
        debug_reset_req <= 1'b0;
        rd(ADDR_PLL_RATIO, v);
        chk("ratio_debug", 32'h5, v);
        rd(ADDR_PLL_STATUS, v);
        chk("lock_flag", 32'h1, v[LOCK_BIT]);
    endtask

    task t_watchdog;
        wr(ADDR_SYS_CTRL, 16'h0002);
        wr(ADDR_WD_CTRL, 16'h0040);
        wr(ADDR_WD_KEY, 16'h0055);
        wr(ADDR_WD_KEY, 16'h00AA);
        rd(ADDR_WD_COUNT, v);
        chk("wd_clear", 32'h0, v);
        wr(ADDR_WD_CTRL, 16'h0000);
        pause(40);
        wr(ADDR_WD_KEY, 16'h0055);
        wr(ADDR_WD_KEY, 16'h0012);
        wr(ADDR_WD_KEY, 16'h00AA);
        rd(ADDR_WD_COUNT, v);
        chk("wd_kept", 32'h1, v > 2);
        for (i = 0; i < 1500 && watchdog_wake_irq_q !== 1'b1; i++) pause(1);
        chk("wd_irq", 32'h1, watchdog_wake_irq_q);
        t = 0;
        for (i = 0; i < 3000 && watchdog_wake_irq_q === 1'b1; i++) begin
            if (osc_tick === 1'b1) t++;
            pause(1);
        end
        chk("wd_width", 32'h1, t >= 511 && t <= 513);
        wr(ADDR_WD_CTRL, 16'h0040);
    endtask

    task t_lowpower;
        wr(ADDR_WAKE_SEL_LO, 16'h0008);
        enter(16'h0000);
        chk("idle", 32'h3, {cpu_clock_on_q, pins_hold_q});
        irq_pending <= 1'b1;
        wait_wake;
        irq_pending <= 1'b0;
        enter(16'h000D);
        chk("standby", 32'h5, {osc_on_q, cpu_clock_on_q, pins_hold_q});
        gpio_a[3] <= 1'b0;
        pause(5);
        gpio_a[3] <= 1'b1;
        pause(8);
        chk("short_pin", 32'h1, pins_hold_q);
        gpio_a[3] <= 1'b0;
        wait_wake;
        gpio_a[3] <= 1'b1;
        enter(16'h0001);
        chk("standby_dbg", 32'h1, pins_hold_q);
        debug_wake <= 1'b1;
        wait_wake;
        debug_wake <= 1'b0;
        enter(16'h0002);
        chk("halt", 32'h1, {osc_on_q, pll_on_q, pins_hold_q});
        external_nmi_n <= 1'b0;
        wait_wake;
        external_nmi_n <= 1'b1;
    endtask

    task t_loss_off;
        wr(ADDR_WD_CTRL, 16'h0000);
        pause(20);
        stop <= 1'b1;
        pause(3);
        chk("limp", 32'h1, limp_select_q);
        rd(ADDR_PLL_STATUS, v);
        chk("missing_flag", 32'h1, v[MCLK_BIT]);
        rd(ADDR_PLL_RATIO, v);
        chk("ratio_kept", 32'h5, v);
        rd(ADDR_WD_COUNT, w);
        pause(40);
        rd(ADDR_WD_COUNT, v);
        chk("wd_frozen", w, v);
        stop <= 1'b0;
        do_reset;
        rd(ADDR_PLL_RATIO, v);
        chk("ratio_reset", 32'h0, v);
        wr(ADDR_PLL_RATIO, 16'h0003);
        for (i = 0; i < 1500 && device_reset_q !== 1'b1; i++) pause(1);
        chk("wd_reset", 32'h1, device_reset_q);
        pause(2);
        rd(ADDR_PLL_RATIO, v);
        chk("ratio_wd_reset", 32'h0, v);
        wr(ADDR_PLL_STATUS, 16'h0010);
        pause(2);
        chk("pll_off", 32'h4, {pll_on_q, pll_mult_q, cpu_div_q});
    endtask

    initial begin
        do_reset;
        t_start_divide;
        t_ratio;
        t_watchdog;
        t_lowpower;
        t_loss_off;
        final_report;
    end
endmodule

// ### wd_timer.sv
`timescale 1ns/1ps
module wd_timer
    import pll_clock_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clear,      // Soft reset of the counter
    input  wire logic       osc_tick,   // One pulse per oscillator cycle
    input  wire logic       run,        // Counting allowed
    input  wire logic       key_wr,     // Write to the key register
    input  wire logic [7:0] key_data,
    output logic      [7:0] count_q,    // Current counter value
    output logic            pulse_q,    // Watchdog output pulse
    output logic            start_q     // One-cycle mark at pulse start
);

    logic       armed_q;                // First key seen
    logic [9:0] pulse_cnt_q;            // Oscillator cycles left in pulse
    wire        key_arm     = key_wr && (key_data == KEY_ARM);
    wire        key_service = key_wr && (key_data == KEY_SERVICE) && armed_q;
    wire        wrap        = run && osc_tick && (count_q == WD_MAX);

    // Key sequence tracking
    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            armed_q <= 1'b0;
        end else if (key_wr) begin
            armed_q <= key_arm;
        end
    end

    // Up counter, cleared by the service key
    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            count_q <= WD_CNT_RST;
        end else if (key_service) begin
            count_q <= WD_CNT_RST;
        end else if (run && osc_tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // Output pulse of fixed oscillator-cycle length
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_cnt_q <= 10'd0;
            pulse_q     <= 1'b0;
            start_q     <= 1'b0;
        end else begin
            start_q <= wrap && !pulse_q;
            if (wrap && !pulse_q) begin
                pulse_cnt_q <= WD_PULSE_CYCLES;
                pulse_q     <= 1'b1;
            end else if (pulse_q && osc_tick) begin
                pulse_cnt_q <= pulse_cnt_q - 10'd1;
                pulse_q     <= (pulse_cnt_q != 10'd1);
            end
        end
    end

endmodule
